// ===== hw/fcpwm_top.v
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "fcpwm_map.vh"

// Operation
// - Four channels, own 8-bit counter/period/duty
// - Duty from always inactive to always active
// - Channel pairs join into one 16-bit output
// - Source per channel: A or S for ch1-2, B or S for ch3-4
// - Period and duty writes buffered until rollover or disable
// - Counter write forces buffered values in
// - Join bit 7: ch3 high, ch4 low, pin 3
// - Join bit 6: ch1 high, ch2 low, pin 1
// - Clock A is E, E/2, E/4, E/8
// - Clock B is E divided by 2^field
// - Clock select bit 3 reads zero
// - Ch4 select: 0 clock B, 1 clock S
// - Clock S derived from A by divisor
// - Enable register; clock select controls joining
// - Polarity sets start level, flips at duty
// - S is A/divisor/2, zero means 256
// - Ch3 B/S, ch1 and ch2 A/S
module fcpwm_top (
    input wire core_clk_i,
    input wire rst_i,
    input wire [9:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    output reg [3:0] pwm_o
);

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    reg [7:0] clk_sel_r;
    reg [7:0] pol_src_r;
    reg [7:0] scale_r;
    reg [3:0] enable_r;
    reg [31:0] per_buf_r;
    reg [31:0] dty_buf_r;

    wire [7:0] idx;
    wire aligned;
    wire wr_go;
    wire rd_go;
    wire [31:0] cnt_flat;
    wire [3:0] cnt_wr;
    wire [3:0] tick;
    wire [3:0] out_nxt;
    wire a_tick;
    wire b_tick;
    wire s_tick;
    reg [7:0] rd_byte;

    // Test whether an index falls inside a bank of four starting at base
    function in_bank;
        input [7:0] i;
        input [7:0] base;
        begin
            in_bank = (i >= base) && (i < base + 8'h04);
        end
    endfunction

    assign idx = avs_address_i[9:2];
    assign aligned = (avs_address_i[1:0] == 2'b00);
    // A write lands only on the edge that sees waitrequest low
    assign wr_go = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0]
                   & aligned;
    assign rd_go = avs_read_i & avs_waitrequest_o;

    // ------------------------------------------------------------------
    // Bus handshake: one wait cycle, then the answer
    // ------------------------------------------------------------------
    // Every access costs one wait state; reads and writes alike
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) &
                                   avs_waitrequest_o);
            if (rd_go) begin
                avs_readdata_o <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Unmapped or misaligned reads answer zero
    always @* begin
        rd_byte = 8'h00;
        if (aligned) begin
            if (idx == `FCPWM_IDX_CLKSEL) begin
                rd_byte = clk_sel_r & ~(8'h01 << `FCPWM_CLKSEL_GAP);
            end else if (idx == `FCPWM_IDX_POLSRC) begin
                rd_byte = pol_src_r;
            end else if (idx == `FCPWM_IDX_SCALE) begin
                rd_byte = scale_r;
            end else if (idx == `FCPWM_IDX_ENABLE) begin
                rd_byte = {4'h0, enable_r};
            end else if (in_bank(idx, `FCPWM_IDX_CNT0)) begin
                rd_byte = cnt_flat[8*(idx[1:0])+:8];
            end else if (in_bank(idx, `FCPWM_IDX_PER0)) begin
                rd_byte = per_buf_r[8*(idx[1:0])+:8];
            end else if (in_bank(idx, `FCPWM_IDX_DTY0)) begin
                rd_byte = dty_buf_r[8*(idx[1:0])+:8];
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            clk_sel_r <= `FCPWM_RST_CLKSEL;
            pol_src_r <= `FCPWM_RST_POLSRC;
            scale_r <= `FCPWM_RST_SCALE;
            enable_r <= `FCPWM_RST_ENABLE;
            per_buf_r <= {4{`FCPWM_RST_PER}};
            dty_buf_r <= {4{`FCPWM_RST_DTY}};
        end else if (wr_go) begin
            if (idx == `FCPWM_IDX_CLKSEL) begin
                // Joining and prescale live in one register
                clk_sel_r <= avs_writedata_i[7:0] &
                             ~(8'h01 << `FCPWM_CLKSEL_GAP);
            end
            if (idx == `FCPWM_IDX_POLSRC) begin
                pol_src_r <= avs_writedata_i[7:0];
            end
            if (idx == `FCPWM_IDX_SCALE) begin
                scale_r <= avs_writedata_i[7:0];
            end
            if (idx == `FCPWM_IDX_ENABLE) begin
                enable_r <= avs_writedata_i[3:0];
            end
            if (in_bank(idx, `FCPWM_IDX_PER0)) begin
                per_buf_r[8*(idx[1:0])+:8] <= avs_writedata_i[7:0];
            end
            if (in_bank(idx, `FCPWM_IDX_DTY0)) begin
                dty_buf_r[8*(idx[1:0])+:8] <= avs_writedata_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------------
    fcpwm_clkgen u_clkgen (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .cka_sel_i(clk_sel_r[`FCPWM_CKA_HI:`FCPWM_CKA_LO]),
        .ckb_sel_i(clk_sel_r[`FCPWM_CKB_HI:`FCPWM_CKB_LO]),
        .scale_i(scale_r),
        .a_tick_o(a_tick),
        .b_tick_o(b_tick),
        .s_tick_o(s_tick)
    );

    // ------------------------------------------------------------------
    // Per-channel tick selection and counter write strobes
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sel
            // Channels 1-2 pick A or S, channels 3-4 pick B or S
            if (gi < 2) begin : g_a
                assign tick[gi] = pol_src_r[`FCPWM_SRC_LO+gi] ?
                                  s_tick : a_tick;
            end else begin : g_b
                assign tick[gi] = pol_src_r[`FCPWM_SRC_LO+gi] ?
                                  s_tick : b_tick;
            end
            assign cnt_wr[gi] = wr_go &&
                                (idx == `FCPWM_IDX_CNT0 + gi);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Channel pairs: two 8-bit modulators or one 16-bit
    // ------------------------------------------------------------------
    // Period zero or a count at period-1 both end the period
    // Active values reload on the wrapping tick, so a new period never
    // cuts the running one short
    function roll;
        input [15:0] c;
        input [15:0] p;
        begin
            roll = (p == 16'h0000) || (c >= p - 16'h0001);
        end
    endfunction

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp = gp + 1) begin : g_pair
            localparam H = 2 * gp;
            localparam L = 2 * gp + 1;
            reg [7:0] ch_r;
            reg [7:0] cl_r;
            reg [7:0] ph_r;
            reg [7:0] pl_r;
            reg [7:0] dh_r;
            reg [7:0] dl_r;
            wire join_w;
            wire [15:0] c16;
            wire [15:0] p16;
            wire [15:0] d16;
            wire r16;
            wire rh;
            wire rl;
            wire pol_h;
            wire pol_l;

            assign join_w = clk_sel_r[`FCPWM_JOIN12_BIT+gp];
            assign c16 = {ch_r, cl_r};
            assign p16 = {ph_r, pl_r};
            assign d16 = {dh_r, dl_r};
            assign r16 = roll(c16, p16);
            assign rh = roll({8'h00, ch_r}, {8'h00, ph_r});
            assign rl = roll({8'h00, cl_r}, {8'h00, pl_r});
            assign pol_h = pol_src_r[`FCPWM_POL_LO+H];
            assign pol_l = pol_src_r[`FCPWM_POL_LO+L];

            always @(posedge core_clk_i) begin
                if (rst_i) begin
                    ch_r <= `FCPWM_RST_CNT;
                    cl_r <= `FCPWM_RST_CNT;
                    ph_r <= `FCPWM_RST_PER;
                    pl_r <= `FCPWM_RST_PER;
                    dh_r <= `FCPWM_RST_DTY;
                    dl_r <= `FCPWM_RST_DTY;
                end else if (join_w) begin
                    // Low channel's enable and clock run the pair
                    if (~enable_r[L] | cnt_wr[H] | cnt_wr[L] |
                        (tick[L] & r16)) begin
                        ph_r <= per_buf_r[8*H+:8];
                        pl_r <= per_buf_r[8*L+:8];
                        dh_r <= dty_buf_r[8*H+:8];
                        dl_r <= dty_buf_r[8*L+:8];
                    end
                    if (~enable_r[L] | cnt_wr[H] | cnt_wr[L]) begin
                        ch_r <= 8'h00;
                        cl_r <= 8'h00;
                    end else if (tick[L]) begin
                        {ch_r, cl_r} <= r16 ? 16'h0000 : c16 + 16'h0001;
                    end
                end else begin
                    if (~enable_r[H] | cnt_wr[H] |
                        (tick[H] & rh)) begin
                        ph_r <= per_buf_r[8*H+:8];
                        dh_r <= dty_buf_r[8*H+:8];
                    end
                    if (~enable_r[H] | cnt_wr[H]) begin
                        ch_r <= 8'h00;
                    end else if (tick[H]) begin
                        ch_r <= rh ? 8'h00 : ch_r + 8'h01;
                    end
                    if (~enable_r[L] | cnt_wr[L] |
                        (tick[L] & rl)) begin
                        pl_r <= per_buf_r[8*L+:8];
                        dl_r <= dty_buf_r[8*L+:8];
                    end
                    if (~enable_r[L] | cnt_wr[L]) begin
                        cl_r <= 8'h00;
                    end else if (tick[L]) begin
                        cl_r <= rl ? 8'h00 : cl_r + 8'h01;
                    end
                end
            end

            // Duty zero gives full active level, duty at or past the
            // period gives none, period zero holds the idle level
            assign out_nxt[H] = join_w ?
                pol_l ^ (enable_r[L] && p16 != 16'h0000 &&
                         c16 >= d16) :
                pol_h ^ (enable_r[H] && ph_r != 8'h00 &&
                         ch_r >= dh_r);
            // Joined output leaves the low pin at its idle level
            assign out_nxt[L] = join_w ? pol_l :
                pol_l ^ (enable_r[L] && pl_r != 8'h00 &&
                         cl_r >= dl_r);

            assign cnt_flat[8*H+:8] = ch_r;
            assign cnt_flat[8*L+:8] = cl_r;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------------
    // Registered pins lag the counter by one clock
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            pwm_o <= 4'h0;
        end else begin
            pwm_o <= out_nxt;
        end
    end

endmodule // fcpwm_top

// ===== hw/fcpwm_map.vh
`ifndef FCPWM_MAP_VH
`define FCPWM_MAP_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define FCPWM_IDX_CLKSEL 8'h60
`define FCPWM_IDX_POLSRC 8'h61
`define FCPWM_IDX_SCALE 8'h62
`define FCPWM_IDX_ENABLE 8'h63
`define FCPWM_IDX_CNT0 8'h64
`define FCPWM_IDX_PER0 8'h68
`define FCPWM_IDX_DTY0 8'h6C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FCPWM_JOIN34_BIT 7
`define FCPWM_JOIN12_BIT 6
`define FCPWM_CKA_HI 5
`define FCPWM_CKA_LO 4
`define FCPWM_CLKSEL_GAP 3
`define FCPWM_CKB_HI 2
`define FCPWM_CKB_LO 0
`define FCPWM_SRC_LO 4
`define FCPWM_POL_LO 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FCPWM_RST_CLKSEL 8'h00
`define FCPWM_RST_POLSRC 8'h00
`define FCPWM_RST_SCALE 8'h00
`define FCPWM_RST_ENABLE 4'h0
`define FCPWM_RST_CNT 8'h00
`define FCPWM_RST_PER 8'hFF
`define FCPWM_RST_DTY 8'hFF

// ----------------------------------------------------------------------
// Prescaler width (largest divide is 2^7)
// ----------------------------------------------------------------------
`define FCPWM_PRE_W 7

`endif

// ===== hw/fcpwm_clkgen.v
`timescale 1ns/1ps
`include "fcpwm_map.vh"

module fcpwm_clkgen (
    input wire core_clk_i,
    input wire rst_i,
    input wire [1:0] cka_sel_i,
    input wire [2:0] ckb_sel_i,
    input wire [7:0] scale_i,
    output reg a_tick_o,
    output reg b_tick_o,
    output reg s_tick_o
);

    // ------------------------------------------------------------------
    // Free-running prescaler
    // ------------------------------------------------------------------
    reg [`FCPWM_PRE_W-1:0] pre_r;
    reg [7:0] s_cnt_r;
    reg s_half_r;

    // Low n bits all ones marks one tick every 2^n clocks
    function [`FCPWM_PRE_W-1:0] pow_mask;
        input [2:0] n;
        begin
            pow_mask = (7'h01 << n) - 7'h01;
        end
    endfunction

    wire a_nxt;
    wire b_nxt;
    wire s_wrap;
    assign a_nxt = (pre_r & pow_mask({1'b0, cka_sel_i})) ==
                   pow_mask({1'b0, cka_sel_i});
    assign b_nxt = (pre_r & pow_mask(ckb_sel_i)) ==
                   pow_mask(ckb_sel_i);
    // Divisor zero wraps after 256 A ticks through the 8-bit rollover
    // A divisor lowered below the running count wraps at once, instead
    // of running the count round through 255 first
    assign s_wrap = (s_cnt_r >= scale_i - 8'h01);

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            pre_r <= {`FCPWM_PRE_W{1'b0}};
            s_cnt_r <= 8'h00;
            s_half_r <= 1'b0;
            a_tick_o <= 1'b0;
            b_tick_o <= 1'b0;
            s_tick_o <= 1'b0;
        end else begin
            pre_r <= pre_r + 7'h01;
            a_tick_o <= a_nxt;
            b_tick_o <= b_nxt;
            s_tick_o <= 1'b0;
            if (a_tick_o) begin
                if (s_wrap) begin
                    s_cnt_r <= 8'h00;
                    s_half_r <= ~s_half_r;
                    s_tick_o <= s_half_r;
                end else begin
                    s_cnt_r <= s_cnt_r + 8'h01;
                end
            end
        end
    end

endmodule // fcpwm_clkgen

// ===== bench/fcpwm_chk.sv
`timescale 1ns/1ps
module fcpwm_chk (
    input wire core_clk_i,
    input wire rst_i,
    input wire [9:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire [3:0] pwm_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------------
    // Shadow of enable, polarity and join, to judge the idle pins
    // ------------------------------------------------------------------
    reg [3:0] en_r;
    reg [3:0] pol_r;
    reg [1:0] join_r;
    wire req = avs_read_i || avs_write_i;
    wire [7:0] idx = avs_address_i[9:2];
    wire rd_done = avs_read_i && !avs_waitrequest_o;
    wire wr_done = avs_write_i && !avs_waitrequest_o &&
        avs_byteenable_i[0] && avs_address_i[1:0] == 2'b00;
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            en_r <= 4'h0;
            pol_r <= 4'h0;
            join_r <= 2'h0;
        end else if (wr_done) begin
            if (idx == 8'h63) en_r <= avs_writedata_i[3:0];
            if (idx == 8'h61) pol_r <= avs_writedata_i[3:0];
            if (idx == 8'h60) join_r <= avs_writedata_i[7:6];
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_wait_answer: assert property (req && avs_waitrequest_o |=>
        !avs_waitrequest_o) else $error("no answer after one wait");
    a_wait_pulse: assert property (!avs_waitrequest_o |=>
        avs_waitrequest_o) else $error("waitrequest low too long");
    a_wait_quiet: assert property (!req && avs_waitrequest_o |=>
        avs_waitrequest_o) else $error("answer without request");
    a_rd_upper: assert property (rd_done |->
        avs_readdata_o[31:8] == 24'h00_0000) else $error("upper bits set");
    a_gap_bit: assert property (rd_done && idx == 8'h60 |->
        !avs_readdata_o[3]) else $error("clock select bit 3 set");
    a_en_upper: assert property (rd_done && idx == 8'h63 |->
        avs_readdata_o[7:4] == 4'h0) else $error("enable upper bits set");
    a_unmapped: assert property (rd_done && (idx < 8'h60 || idx > 8'h6f ||
        avs_address_i[1:0] != 2'b00) |-> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_reset_state: assert property ($fell(rst_i) |-> avs_waitrequest_o &&
        pwm_o == 4'h0) else $error("bad state after reset");
    a_pin4_idle: assert property ($stable(en_r) && $stable(pol_r) &&
        $stable(join_r) && (!en_r[3] || join_r[1]) |-> pwm_o[3] == pol_r[3])
        else $error("pin 4 not at polarity");
    a_pin2_idle: assert property ($stable(en_r) && $stable(pol_r) &&
        $stable(join_r) && (!en_r[1] || join_r[0]) |-> pwm_o[1] == pol_r[1])
        else $error("pin 2 not at polarity");
endmodule // fcpwm_chk

bind fcpwm_top fcpwm_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pwm_o(pwm_o));

// ===== bench/fcpwm_pin_load.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port pin loads: count high cycles and rising edges in a window
// ----------------------------------------------------------------------
module fcpwm_pin_load (
    input wire core_clk_i,
    input wire clr_i,
    input wire en_i,
    input wire [3:0] pin_i,
    output reg [63:0] high_o,
    output reg [63:0] rise_o
);
    reg [3:0] last_r;
    integer k;
    always @(posedge core_clk_i) begin
        last_r <= pin_i;
        for (k = 0; k < 4; k = k + 1) begin
            if (clr_i) begin
                high_o[k*16 +: 16] <= 16'h0000;
                rise_o[k*16 +: 16] <= 16'h0000;
            end else if (en_i) begin
                high_o[k*16 +: 16] <= high_o[k*16 +: 16] + pin_i[k];
                rise_o[k*16 +: 16] <= rise_o[k*16 +: 16] +
                    (pin_i[k] && !last_r[k]);
            end
        end
    end
endmodule // fcpwm_pin_load

// ===== bench/tb_four_channel_pwm_timer.sv
`timescale 1ns/1ps
module tb_four_channel_pwm_timer;
    reg core_clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [9:0] addr = 10'h000;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wdata = 32'h0000_0000;
    reg [3:0] ben = 4'h0;
    reg clr = 1'b0;
    reg en = 1'b0;
    wire [31:0] rdata;
    wire wreq;
    wire [3:0] pwm;
    wire [63:0] high;
    wire [63:0] rise;
    reg [31:0] q;
    integer errors = 0;
    integer comparisons = 0;
    integer i;
    always #2 core_clk_i = !core_clk_i;
    fcpwm_top uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(ben),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .pwm_o(pwm));
    fcpwm_pin_load u_load (.core_clk_i(core_clk_i), .clr_i(clr), .en_i(en),
        .pin_i(pwm), .high_o(high), .rise_o(rise));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task results;
        begin
            $display("errors=%0d comparisons=%0d", errors, comparisons);
            if (errors == 0 && comparisons > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Holds the request until waitrequest is seen low at an edge
    task bus(input w, input [7:0] idx, input [7:0] d, input [3:0] be);
        integer n;
        begin
            @(posedge core_clk_i);
            addr <= {idx, 2'b00};
            rd <= !w;
            wr <= w;
            wdata <= {24'h00_0000, d};
            ben <= be;
            n = 0;
            @(posedge core_clk_i);
            while (wreq !== 1'b0 && n < 20) begin
                @(posedge core_clk_i);
                n = n + 1;
            end
            q = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
            if (n == 20) begin
                errors = errors + 1;
                $display("[FAIL] %0t bus timeout", $time);
                results;
            end
        end
    endtask
    task wreg(input [7:0] idx, input [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask
    task rchk(input [7:0] idx, input [7:0] exp);
        begin
            bus(1'b0, idx, 8'h00, 4'h1);
            check(q, {24'h00_0000, exp});
        end
    endtask
    task measure(input integer w);
        begin
            @(posedge core_clk_i);
            clr <= 1'b1;
            @(posedge core_clk_i);
            clr <= 1'b0;
            en <= 1'b1;
            repeat (w) @(posedge core_clk_i);
            en <= 1'b0;
            #1;
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_regs;
        begin
            for (i = 0; i < 16; i = i + 1)
                rchk(8'h60 + i, (i < 8) ? 8'h00 : 8'hff);
            rchk(8'h10, 8'h00);
            wreg(8'h60, 8'hff);
            rchk(8'h60, 8'hf7);
            wreg(8'h63, 8'hff);
            rchk(8'h63, 8'h0f);
            bus(1'b1, 8'h61, 8'h55, 4'h0);
            rchk(8'h61, 8'h00);
            wreg(8'h60, 8'h00);
            wreg(8'h63, 8'h00);
        end
    endtask
    // Period 4 on channel 1: high-time per polarity and duty
    task t_wave;
        reg [8:0] tab [0:3];
        begin
            tab[0] = 9'h1_01;
            tab[1] = 9'h0_01;
            tab[2] = 9'h1_00;
            tab[3] = 9'h1_04;
            wreg(8'h68, 8'h04);
            wreg(8'h63, 8'h01);
            for (i = 0; i < 4; i = i + 1) begin
                wreg(8'h6c, tab[i][7:0]);
                wreg(8'h61, {7'h00, !tab[i][8]});
                repeat (8) @(posedge core_clk_i);
                measure(40);
                check(high[15:0], tab[i][8] ? 40 - tab[i][7:0] * 10
                    : tab[i][7:0] * 10);
            end
            wreg(8'h61, 8'h00);
            wreg(8'h6c, 8'h01);
            for (i = 0; i < 4; i = i + 1) begin
                wreg(8'h60, i << 4);
                repeat (64) @(posedge core_clk_i);
                measure(128 << i);
                check(rise[15:0], 32);
            end
        end
    endtask
    task t_clkb;
        begin
            wreg(8'h6a, 8'h02);
            wreg(8'h6e, 8'h01);
            wreg(8'h63, 8'h04);
            for (i = 0; i < 8; i = i + 1) begin
                wreg(8'h60, i);
                repeat (8 << i) @(posedge core_clk_i);
                measure(16 << i);
                check(rise[47:32], 8);
                check(high[47:32], 8 << i);
            end
        end
    endtask
    task t_scaled;
        begin
            wreg(8'h60, 8'h00);
            wreg(8'h61, 8'hf0);
            wreg(8'h68, 8'h02);
            wreg(8'h69, 8'h02);
            wreg(8'h6d, 8'h01);
            wreg(8'h6b, 8'h02);
            wreg(8'h6f, 8'h01);
            wreg(8'h63, 8'h0f);
            wreg(8'h62, 8'h03);
            repeat (24) @(posedge core_clk_i);
            measure(120);
            check(rise[31:16], 10);
            check(rise[63:48], 10);
            check(rise[15:0], 10);
            check(rise[47:32], 10);
            wreg(8'h62, 8'h00);
            repeat (2048) @(posedge core_clk_i);
            measure(2048);
            check(rise[63:48], 2);
            check(rise[47:32], 2);
            check(high[31:16], 1024);
        end
    endtask
    task t_join;
        begin
            wreg(8'h61, 8'h00);
            wreg(8'h60, 8'hc0);
            for (i = 0; i < 4; i = i + 2) begin
                wreg(8'h68 + i, 8'h01);
                wreg(8'h69 + i, 8'h00);
                wreg(8'h6c + i, 8'h00);
                wreg(8'h6d + i, 8'h40);
                wreg(8'h64 + i, 8'h00);
            end
            repeat (4) @(posedge core_clk_i);
            measure(512);
            check(high[15:0], 384);
            check(rise[15:0], 2);
            check(high[47:32], 384);
            check(high[31:16] | high[63:48], 0);
        end
    endtask
    task t_buffer;
        begin
            wreg(8'h60, 8'h00);
            wreg(8'h63, 8'h01);
            wreg(8'h68, 8'hff);
            wreg(8'h6c, 8'h80);
            wreg(8'h64, 8'h00);
            wreg(8'h68, 8'h04);
            wreg(8'h6c, 8'h02);
            measure(40);
            check(high[15:0], 0);
            repeat (300) @(posedge core_clk_i);
            measure(40);
            check(high[15:0], 20);
            wreg(8'h68, 8'hff);
            wreg(8'h6c, 8'h80);
            wreg(8'h64, 8'h00);
            measure(40);
            check(high[15:0], 0);
        end
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_wave;
        t_clkb;
        t_scaled;
        t_join;
        t_buffer;
        results;
    end
endmodule // tb_four_channel_pwm_timer
